// file: core/thmro_readout.sv
`timescale 1ns/10ps
`default_nettype none

module thmro_readout
	import thmro_pkg::*;
#(
	parameter int unsigned NUM_CORES = THMRO_NUM_CORES,
	parameter int unsigned CODE_W    = THMRO_CODE_W
)
(
	input  wire logic                                    clk_sys,
	input  wire logic                                    resetn,
	input  wire thmro_sample_t                           sensor_sample,
	input  wire thmro_ctrl_t                             ctrl,
	output logic                                         meas_start,
	output logic [THMRO_STATUS_W-1:0]                    temp_sensor_status,
	output logic [THMRO_NUM_CORES-1:0][THMRO_CODE_W-1:0] core_temp,
	output logic                                         alert_pending,
	output logic                                         alert_irq
);

	// upper bound of the code field inside the status word
	localparam int unsigned CODE_HI = THMRO_CODE_LSB + THMRO_CODE_W;

	// the carriers come from the package, so the parameters must agree
	if (NUM_CORES != THMRO_NUM_CORES) begin : g_chk_cores
		$error("thmro_readout: NUM_CORES must match the sample carrier");
	end

	if (CODE_W != THMRO_CODE_W) begin : g_chk_code
		$error("thmro_readout: CODE_W must match the sample carrier");
	end

	if (NUM_CORES == 0 || CODE_W == 0) begin : g_chk_zero
		$error("thmro_readout: core count and code width must be nonzero");
	end

	if (CODE_HI > THMRO_STATUS_W) begin : g_chk_fit
		$error("thmro_readout: code field does not fit the status word");
	end

	if (THMRO_DLY_W == 0) begin : g_chk_dly
		$error("thmro_readout: delay counter needs at least one bit");
	end

	typedef struct packed {
		// measurement sequencer
		thmro_seq_t                                   seq;
		logic [THMRO_DLY_W-1:0]                       dly_cnt;
		logic                                         start;

		// captured codes
		logic [THMRO_NUM_CORES-1:0][THMRO_CODE_W-1:0] core_code;
		logic [THMRO_CODE_W-1:0]                      current_temp_code;

		// alert path
		logic [THMRO_CODE_W-1:0]                      thr;
		logic                                         thr_stable;
		logic                                         above;
		logic                                         pend;
		logic                                         irq;
	} thmro_state_t;

	localparam thmro_state_t THMRO_STATE_RST = '{
		seq:               THMRO_SEQ_WAIT,
		dly_cnt:           THMRO_DLY_RST,
		start:             1'b0,

		core_code:         '0,
		current_temp_code: THMRO_CODE_RST,

		thr:               THMRO_THR_RST,
		thr_stable:        1'b0,
		above:             1'b0,
		pend:              1'b0,
		irq:               1'b0
	};

	thmro_state_t state_q;
	thmro_state_t state_d;

	logic         dly_zero;
	logic         thr_moved;
	logic         armed;
	logic         hot;
	logic         rising;
	logic         alert_evt;
	logic         pend_keep;

	logic [THMRO_NUM_CORES-1:0][THMRO_CODE_W-1:0] core_next;
	wire  logic [THMRO_STATUS_W-1:0]              status_bits;

	// one capture lane per core, loaded only on a finished measurement
	for (genvar i = 0; i < THMRO_NUM_CORES; i++) begin : g_core
		logic [THMRO_CODE_W-1:0] lane_new;
		logic [THMRO_CODE_W-1:0] lane_old;
		assign lane_new     = sensor_sample.core_code[i];
		assign lane_old     = state_q.core_code[i];
		assign core_next[i] = sensor_sample.done ? lane_new : lane_old;
	end

	// status word: code field from the flop, every other bit tied low
	// so software can mask nothing and still read a clean code
	for (genvar b = 0; b < THMRO_STATUS_W; b++) begin : g_status
		if (b >= THMRO_CODE_LSB && b < CODE_HI) begin : g_code
			assign status_bits[b] =
				state_q.current_temp_code[b - THMRO_CODE_LSB];
		end else begin : g_zero
			assign status_bits[b] = 1'b0;
		end
	end

	always_comb begin
		state_d.seq               = state_q.seq;
		state_d.dly_cnt           = state_q.dly_cnt;
		state_d.start             = state_q.start;

		state_d.core_code         = state_q.core_code;
		state_d.current_temp_code = state_q.current_temp_code;

		state_d.thr               = state_q.thr;
		state_d.thr_stable        = state_q.thr_stable;
		state_d.above             = state_q.above;
		state_d.pend              = state_q.pend;
		state_d.irq               = state_q.irq;

		dly_zero  = (state_q.dly_cnt == '0);
		thr_moved = (ctrl.threshold != state_q.thr);
		armed     = 1'b0;
		hot       = 1'b0;
		rising    = 1'b0;
		alert_evt = 1'b0;
		pend_keep = 1'b0;

		// start is a one-cycle strobe; only the wait-to-measure step sets it
		state_d.start = 1'b0;

		case (state_q.seq)
			THMRO_SEQ_WAIT: begin
				if (dly_zero) begin
					state_d.seq   = THMRO_SEQ_MEAS;
					state_d.start = 1'b1;
				end else begin
					state_d.seq     = THMRO_SEQ_WAIT;
					state_d.dly_cnt = state_q.dly_cnt - 1'b1;
				end
			end

			THMRO_SEQ_MEAS: begin
				// no new start until the sensor reports done
				if (sensor_sample.done) begin
					state_d.seq     = THMRO_SEQ_WAIT;
					state_d.dly_cnt = ctrl.counter_delay;
				end else begin
					state_d.seq     = THMRO_SEQ_MEAS;
				end
			end

			default: begin
				state_d.seq     = THMRO_SEQ_WAIT;
				state_d.dly_cnt = THMRO_DLY_RST;
			end
		endcase

		// whole-word capture: software never sees a half-updated code
		state_d.core_code = core_next;
		if (sensor_sample.done) begin
			state_d.current_temp_code = sensor_sample.cur_code;
		end

		// a threshold change blocks alert events until it has settled a cycle
		state_d.thr        = ctrl.threshold;
		state_d.thr_stable = ~thr_moved;

		// only flopped copies meet here, never the live sensor bus
		hot           = (state_q.current_temp_code >= state_q.thr);
		rising        = hot & ~state_q.above;
		armed         = state_q.thr_stable;
		state_d.above = hot;
		if (armed) begin
			alert_evt = rising;
		end
		// unsettled threshold: rebaseline without raising an event

		// set beats clear so a same-cycle crossing is not lost
		pend_keep    = state_q.pend & ~ctrl.pend_clr;
		state_d.pend = alert_evt | pend_keep;
		state_d.irq  = state_d.pend & ctrl.irq_en;
	end

	// async reset loads constants only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= THMRO_STATE_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// every output is a register or a constant tie
	assign meas_start         = state_q.start;
	assign core_temp          = state_q.core_code;
	assign alert_pending      = state_q.pend;
	assign alert_irq          = state_q.irq;
	assign temp_sensor_status = status_bits;

endmodule

`default_nettype wire

// file: shared/thmro_pkg.sv
package thmro_pkg;

	localparam int unsigned THMRO_NUM_CORES = 6;
	localparam int unsigned THMRO_CODE_W    = 10;
	localparam int unsigned THMRO_DLY_W     = 16;
	localparam int unsigned THMRO_STATUS_W  = 32;
	localparam int unsigned THMRO_CODE_LSB  = 0;

	localparam logic [THMRO_CODE_W-1:0] THMRO_CODE_RST = 10'h000;
	localparam logic [THMRO_CODE_W-1:0] THMRO_THR_RST  = 10'h3ff;
	localparam logic [THMRO_DLY_W-1:0]  THMRO_DLY_RST  = 16'h0000;

	typedef enum logic [0:0] {
		THMRO_SEQ_WAIT = 1'b0,
		THMRO_SEQ_MEAS = 1'b1
	} thmro_seq_t;

	typedef struct packed {
		logic                                         done;
		logic [THMRO_CODE_W-1:0]                      cur_code;
		logic [THMRO_NUM_CORES-1:0][THMRO_CODE_W-1:0] core_code;
	} thmro_sample_t;

	typedef struct packed {
		logic                   irq_en;
		logic                   pend_clr;
		logic [THMRO_CODE_W-1:0] threshold;
		logic [THMRO_DLY_W-1:0]  counter_delay;
	} thmro_ctrl_t;

endpackage

// file: testbench/thmro_readout_sva.sv
`timescale 1ns/10ps
`default_nettype none
module thmro_readout_sva
	import thmro_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          resetn,
	input wire thmro_sample_t sensor_sample,
	input wire thmro_ctrl_t   ctrl,
	input wire logic          meas_start,
	input wire logic [31:0]   temp_sensor_status,
	input wire logic [5:0][9:0] core_temp,
	input wire logic          alert_pending,
	input wire logic          alert_irq
);
	wire logic [9:0] cur = temp_sensor_status[9:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_irq_gate: assert property (alert_irq |-> alert_pending)
		else $error("irq");
	a_code_take: assert property (sensor_sample.done |=>
		temp_sensor_status == {22'h0, $past(sensor_sample.cur_code)})
		else $error("code");
	a_core_take: assert property (sensor_sample.done |=>
		core_temp == $past(sensor_sample.core_code)) else $error("core");
	a_code_hold: assert property (!$past(sensor_sample.done) |->
		$stable(temp_sensor_status)) else $error("hold");
	a_no_below: assert property ($rose(alert_pending) |->
		cur >= ctrl.threshold) else $error("below");
	a_thr_settled: assert property ($rose(alert_pending) |->
		$past(ctrl.threshold, 2) == $past(ctrl.threshold))
		else $error("thr");
	a_thr_quiet: assert property ($changed(ctrl.threshold) |=>
		!$rose(alert_pending)) else $error("spur");
	a_meas_gap: assert property (sensor_sample.done &&
		ctrl.counter_delay == 16'h0003 |=> !meas_start [*3] ##[1:5]
		meas_start) else $error("gap");
	c_alert: cover property ($rose(alert_pending));
	c_masked: cover property (alert_pending && !alert_irq);
	c_start: cover property (meas_start);
endmodule
bind thmro_readout thmro_readout_sva chk (.clk_sys(clk_sys),
	.resetn(resetn), .sensor_sample(sensor_sample), .ctrl(ctrl),
	.meas_start(meas_start), .temp_sensor_status(temp_sensor_status),
	.core_temp(core_temp), .alert_pending(alert_pending),
	.alert_irq(alert_irq));
`default_nettype wire

// file: testbench/thmro_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
module thmro_sensor_model
	import thmro_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       meas_start,
	input  wire logic [9:0] temp,
	output thmro_sample_t   smp
);
	initial begin
		smp = '0;
		forever begin
			@(posedge clk_sys);
			if (meas_start === 1'b1) begin
				// conversion time varies with the code
				repeat (temp[1:0]) @(posedge clk_sys);
				#2 smp.cur_code = temp;
				for (int i = 0; i < 6; i++) smp.core_code[i] = temp + 10'(i);
				smp.done = 1'b1;
				@(posedge clk_sys);
				// inverted so a stale capture cannot pass
				#2 smp = ~smp;
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/tb_thmro_readout.sv
`timescale 1ns/10ps
`default_nettype none
module tb_thmro_readout import thmro_pkg::*;;
	logic clk_sys = 1'b0, resetn = 1'b0, meas_start, alert_pending, alert_irq;
	thmro_ctrl_t   ctrl = '0;
	thmro_sample_t sensor_sample;
	logic [31:0]   temp_sensor_status;
	logic [5:0][9:0] core_temp;
	logic [9:0]    temp = '0;
	logic [9:0]    rd;
	int seed = 72, n_mismatch = 0, num_checks = 0, cyc = 0, p = 0, ep = 0;
	initial forever #25 clk_sys = ~clk_sys;
	thmro_readout uut (.clk_sys, .resetn, .sensor_sample, .ctrl,
		.meas_start, .temp_sensor_status, .core_temp, .alert_pending,
		.alert_irq);
	thmro_sensor_model sm (.clk_sys, .meas_start, .temp,
		.smp(sensor_sample));
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// software read: two reads, a third only when the first two differ
	task automatic sw_read(output logic [9:0] v);
		logic [9:0] r1, r2;
		r1 = temp_sensor_status[9:0];
		@(posedge clk_sys) #2 r2 = temp_sensor_status[9:0];
		v = r2;
		if (r1 !== r2) begin
			@(posedge clk_sys) #2 v = temp_sensor_status[9:0];
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk_sys) if (++cyc == 20000) begin
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#2 resetn = 1'b1;
		ctrl.counter_delay = 16'h0003;
		@(posedge clk_sys) #2 ctrl.threshold = 10'h1f4;
		@(posedge clk_sys) #2 ctrl.pend_clr = 1'b1;
		@(posedge clk_sys) #2 ctrl.pend_clr = 1'b0;
		do @(posedge clk_sys); while (sensor_sample.done !== 1'b1);
		#2;
		for (int i = 0; i < 40; i++) begin
			// below, crossing, then held above the limit
			temp = (i % 6 < 3) ? 10'h1e0 + 10'(i % 8)
				: 10'h1f4 + 10'($random(seed) & 7);
			ctrl.irq_en = (i != 15);
			do @(posedge clk_sys); while (sensor_sample.done !== 1'b1);
			#2 chk(temp_sensor_status, {22'h0, temp});
			for (int k = 0; k < 6; k++) chk(core_temp[k], temp + 10'(k));
			sw_read(rd);
			chk(rd, temp);
			if (p < 'h1f4 && temp >= 'h1f4) ep = 1;
			p = temp;
			@(posedge clk_sys) #2 chk(alert_pending, ep);
			chk(alert_irq, ep & (i != 15));
			ctrl.pend_clr = ep[0];
			ep = 0;
			@(posedge clk_sys) #2 ctrl.pend_clr = 1'b0;
		end
		stop_test();
	end
endmodule
`default_nettype wire
